// ==== design/iwd_pkg.sv ====
// Shared constants, enumerations and carriers for the instruction word decoder
`default_nettype none

package iwd_pkg;

    // Word and field widths
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 13;
    localparam int BSEL_W = 3;
    localparam int LIT11_W = 11;

    // Field positions inside the instruction word
    localparam int CLASS_HI = 13;
    localparam int CLASS_LO = 12;
    localparam int DEST_BIT = 7;
    localparam int BSEL_LO = 7;

    // Highest file register address
    localparam logic [6:0] FADDR_LAST = 7'h7F;
    // Address of the first I/O port register, read from its pins
    localparam logic [6:0] FIRST_IO_PORT_ADDR = 7'h05;

    // Values after reset
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [13:0] NOP_WORD = 14'h0000;

    // Return codes in the low seven bits of the control group
    localparam logic [6:0] RETURN_CODE = 7'h08;
    localparam logic [6:0] RETFIE_CODE = 7'h09;

    // Timing: oscillator periods per instruction cycle, clock period
    localparam int OSC_PER_CYCLE = 4;
    localparam int REF_CLK_PERIOD_NS = 8;
    localparam int CYCLE_TIME_NS = OSC_PER_CYCLE * REF_CLK_PERIOD_NS;
    localparam int STACK_DEPTH = 8;

    // Instruction classes
    typedef enum logic [1:0] {CLS_BYTE, CLS_BIT, CLS_LIT} iwd_class_t;

    // Oscillator phases within one instruction cycle
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} iwd_phase_t;

    // Data path operations
    typedef enum logic [4:0] {
        ALU_NONE, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_MOVE, ALU_CLR,
        ALU_COM, ALU_INC, ALU_DEC, ALU_RR, ALU_RL, ALU_SWAP, ALU_BCLR, ALU_BSET,
        ALU_PASSW
    } iwd_alu_op_t;

    // Program flow actions
    typedef enum logic [2:0] {
        CTL_NONE, CTL_GOTO, CTL_CALL, CTL_RET, CTL_RETLW, CTL_SKIPZ, CTL_SKIPBC, CTL_SKIPBS
    } iwd_ctl_t;

    // Status flags: carry, nibble carry, zero
    typedef struct packed {
        logic c;
        logic nibble_carry_flag;
        logic z;
    } iwd_flags_t;

    // Decoded instruction
    typedef struct packed {
        iwd_class_t cls;
        iwd_alu_op_t alu_op;
        iwd_ctl_t ctl;
        logic uses_file;
        logic wr_file;
        logic wr_w;
        logic [6:0] faddr;
        logic [2:0] bsel;
        logic [7:0] lit8;
        logic [10:0] lit11;
    } iwd_dec_t;

endpackage : iwd_pkg

`default_nettype wire

// ==== design/iwd_phase.sv ====
// Four-phase instruction cycle sequencer
`default_nettype none

module iwd_phase (
    input wire logic clk,
    input wire logic rst_n,
    output iwd_pkg::iwd_phase_t phase
);
    import iwd_pkg::*;

    // Phase advances every oscillator period and wraps after the fourth
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_Q1;
        end else begin
            case (phase)
                PH_Q1: phase <= PH_Q2;
                PH_Q2: phase <= PH_Q3;
                PH_Q3: phase <= PH_Q4;
                PH_Q4: phase <= PH_Q1;
                default: phase <= PH_Q1;
            endcase
        end
    end

endmodule : iwd_phase

`default_nettype wire

// ==== design/iwd_alu.sv ====
// Byte data path with flag generation
`default_nettype none

module iwd_alu (
    input wire iwd_pkg::iwd_alu_op_t op,
    input wire logic [7:0] opnd_a,
    input wire logic [7:0] acc,
    input wire logic carry_in,
    input wire logic [2:0] bit_sel,
    output logic [7:0] result,
    output iwd_pkg::iwd_flags_t flags,
    output iwd_pkg::iwd_flags_t upd
);
    import iwd_pkg::*;

    logic [8:0] sum9; // Byte sum with carry out
    logic [4:0] nib5; // Low nibble sum with nibble carry
    logic [7:0] bmask; // One-hot mask of the selected bit

    // Subtraction adds the complement so carry means no borrow
    always_comb begin
        sum9 = 9'h000;
        nib5 = 5'h00;
        bmask = 8'h01 << bit_sel;
        result = acc;
        flags.c = carry_in;
        flags.nibble_carry_flag = 1'b0;
        upd = 3'b000;
        case (op)
            ALU_ADD: begin
                sum9 = {1'b0, opnd_a} + {1'b0, acc};
                nib5 = {1'b0, opnd_a[3:0]} + {1'b0, acc[3:0]};
                result = sum9[7:0];
                upd = 3'b111;
            end
            ALU_SUB: begin
                sum9 = {1'b0, opnd_a} + {1'b0, ~acc} + 9'h001;
                nib5 = {1'b0, opnd_a[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                result = sum9[7:0];
                upd = 3'b111;
            end
            ALU_AND: begin result = opnd_a & acc; upd.z = 1'b1; end
            ALU_OR: begin result = opnd_a | acc; upd.z = 1'b1; end
            ALU_XOR: begin result = opnd_a ^ acc; upd.z = 1'b1; end
            ALU_MOVE: begin result = opnd_a; upd.z = 1'b1; end
            ALU_CLR: begin result = 8'h00; upd.z = 1'b1; end
            ALU_COM: begin result = ~opnd_a; upd.z = 1'b1; end
            ALU_INC: begin result = opnd_a + 8'h01; upd.z = 1'b1; end
            ALU_DEC: begin result = opnd_a - 8'h01; upd.z = 1'b1; end
            ALU_RR: begin
                result = {carry_in, opnd_a[7:1]};
                flags.c = opnd_a[0];
                upd.c = 1'b1;
            end
            ALU_RL: begin
                result = {opnd_a[6:0], carry_in};
                flags.c = opnd_a[7];
                upd.c = 1'b1;
            end
            ALU_SWAP: result = {opnd_a[3:0], opnd_a[7:4]};
            ALU_BCLR: result = opnd_a & ~bmask;
            ALU_BSET: result = opnd_a | bmask;
            ALU_PASSW: result = acc;
            default: result = acc;
        endcase
        if (op == ALU_ADD || op == ALU_SUB) begin
            flags.c = sum9[8];
            flags.nibble_carry_flag = nib5[4];
        end
        flags.z = (result == 8'h00);
    end

endmodule : iwd_alu

`default_nettype wire

// ==== design/iwd_core.sv ====
// Instruction word decoder and executor for the 8-bit core
`default_nettype none

module iwd_core #(
    parameter int STACK_DEPTH = iwd_pkg::STACK_DEPTH
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [iwd_pkg::INSTR_W-1:0] INSTR_WORD,
    input wire logic [iwd_pkg::DATA_W-1:0] FILE_RDATA,
    input wire logic [iwd_pkg::DATA_W-1:0] PORT_PINS,
    output logic [iwd_pkg::PC_W-1:0] PROG_ADDR,
    output logic [iwd_pkg::FADDR_W-1:0] FILE_ADDR,
    output logic FILE_RD,
    output logic FILE_WR,
    output logic [iwd_pkg::DATA_W-1:0] FILE_WDATA,
    output logic PORT_READ,
    output logic [iwd_pkg::DATA_W-1:0] ACCUM,
    output iwd_pkg::iwd_flags_t FLAGS,
    output logic NOP_CYCLE
);
    import iwd_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    iwd_phase_t ph; // Current oscillator phase
    logic [INSTR_W-1:0] ir_ff; // Instruction under execution
    logic [DATA_W-1:0] opnd_ff; // Value read from file or pins
    logic [PC_W-1:0] pc_ff; // Program counter
    logic [DATA_W-1:0] w_ff; // Accumulator
    iwd_flags_t flg_ff; // Status flags
    logic nop_ff; // Current cycle is a forced NOP
    logic rd_ff; // File read strobe
    logic wr_ff; // File write strobe
    logic [DATA_W-1:0] wdata_ff; // File write data
    logic [FADDR_W-1:0] faddr_ff; // File address driven out
    logic port_rd_ff; // First port is being read
    logic [SP_W-1:0] sp_ff; // Return stack pointer
    logic [PC_W-1:0] stk_mem [STACK_DEPTH]; // Return address stack
    iwd_dec_t dec; // Decoded fields of ir_ff
    logic [DATA_W-1:0] alu_a; // Data path operand
    logic [DATA_W-1:0] alu_res; // Data path result
    iwd_flags_t alu_flg; // Flags from the data path
    iwd_flags_t alu_upd; // Which flags the operation changes
    logic skip_take; // Conditional test is true
    logic two_cycle; // Instruction needs a second NOP cycle
    logic [PC_W-1:0] pc_inc; // Address of next word
    logic [PC_W-1:0] nxt_pc; // Program counter after this cycle

    iwd_phase u_phase (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .phase(ph)
    );

    // Literal operations act on the literal, the rest on the read value
    assign alu_a = (dec.cls == CLS_LIT) ? dec.lit8 : opnd_ff;

    iwd_alu u_alu (
        .op(dec.alu_op),
        .opnd_a(alu_a),
        .acc(w_ff),
        .carry_in(flg_ff.c),
        .bit_sel(dec.bsel),
        .result(alu_res),
        .flags(alu_flg),
        .upd(alu_upd)
    );

    // Decoder: class from the top two bits, operands from the rest
    always_comb begin
        dec = '0;
        dec.faddr = ir_ff[FADDR_W-1:0];
        dec.bsel = ir_ff[BSEL_LO +: BSEL_W];
        dec.lit8 = ir_ff[DATA_W-1:0];
        dec.lit11 = ir_ff[LIT11_W-1:0];
        dec.cls = CLS_LIT;
        dec.alu_op = ALU_NONE;
        dec.ctl = CTL_NONE;
        case (ir_ff[CLASS_HI:CLASS_LO])
            2'b00: begin
                dec.cls = CLS_BYTE;
                case (ir_ff[11:8])
                    4'h0: begin
                        if (ir_ff[DEST_BIT]) begin
                            dec.alu_op = ALU_PASSW;
                            dec.uses_file = 1'b1;
                            dec.wr_file = 1'b1;
                        end else begin
                            // control group; unknown codes run as NOP
                            dec.cls = CLS_LIT;
                            if (ir_ff[6:0] == RETURN_CODE || ir_ff[6:0] == RETFIE_CODE) begin
                                dec.ctl = CTL_RET;
                            end
                        end
                    end
                    4'h1: begin
                        // low bits of accumulator clear are ignored
                        dec.alu_op = ALU_CLR;
                        dec.uses_file = ir_ff[DEST_BIT];
                        dec.wr_file = ir_ff[DEST_BIT];
                        dec.wr_w = ~ir_ff[DEST_BIT];
                    end
                    default: begin
                        case (ir_ff[11:8])
                            4'h2: dec.alu_op = ALU_SUB;
                            4'h3: dec.alu_op = ALU_DEC;
                            4'h4: dec.alu_op = ALU_OR;
                            4'h5: dec.alu_op = ALU_AND;
                            4'h6: dec.alu_op = ALU_XOR;
                            4'h7: dec.alu_op = ALU_ADD;
                            4'h8: dec.alu_op = ALU_MOVE;
                            4'h9: dec.alu_op = ALU_COM;
                            4'hA: dec.alu_op = ALU_INC;
                            4'hB: dec.alu_op = ALU_DEC;
                            4'hC: dec.alu_op = ALU_RR;
                            4'hD: dec.alu_op = ALU_RL;
                            4'hE: dec.alu_op = ALU_SWAP;
                            default: dec.alu_op = ALU_INC;
                        endcase
                        if (ir_ff[11:8] == 4'hB || ir_ff[11:8] == 4'hF) begin
                            dec.ctl = CTL_SKIPZ;
                        end
                        dec.uses_file = 1'b1;
                        dec.wr_file = ir_ff[DEST_BIT];
                        dec.wr_w = ~ir_ff[DEST_BIT];
                    end
                endcase
            end
            2'b01: begin
                dec.cls = CLS_BIT;
                dec.uses_file = 1'b1;
                case (ir_ff[11:10])
                    2'b00: begin dec.alu_op = ALU_BCLR; dec.wr_file = 1'b1; end
                    2'b01: begin dec.alu_op = ALU_BSET; dec.wr_file = 1'b1; end
                    2'b10: dec.ctl = CTL_SKIPBC;
                    default: dec.ctl = CTL_SKIPBS;
                endcase
            end
            2'b10: dec.ctl = ir_ff[11] ? CTL_GOTO : CTL_CALL;
            default: begin
                casez (ir_ff[11:8])
                    4'b00??: begin dec.alu_op = ALU_MOVE; dec.wr_w = 1'b1; end
                    4'b01??: dec.ctl = CTL_RETLW;
                    4'b1000: begin dec.alu_op = ALU_OR; dec.wr_w = 1'b1; end
                    4'b1001: begin dec.alu_op = ALU_AND; dec.wr_w = 1'b1; end
                    4'b1010: begin dec.alu_op = ALU_XOR; dec.wr_w = 1'b1; end
                    4'b110?: begin dec.alu_op = ALU_SUB; dec.wr_w = 1'b1; end
                    4'b111?: begin dec.alu_op = ALU_ADD; dec.wr_w = 1'b1; end
                    default: dec.alu_op = ALU_NONE;
                endcase
            end
        endcase
    end

    // Skip and flow decisions, taken in the fourth phase
    always_comb begin
        pc_inc = PC_W'(pc_ff + 13'h0001);
        skip_take = 1'b0;
        case (dec.ctl)
            CTL_SKIPZ: skip_take = (alu_res == 8'h00);
            CTL_SKIPBC: skip_take = ~opnd_ff[dec.bsel];
            CTL_SKIPBS: skip_take = opnd_ff[dec.bsel];
            default: skip_take = 1'b0;
        endcase
        two_cycle = skip_take || (dec.ctl inside {CTL_GOTO, CTL_CALL, CTL_RET, CTL_RETLW});
        case (dec.ctl)
            // eleven-bit target within the current page
            CTL_GOTO, CTL_CALL: nxt_pc = {pc_ff[PC_W-1:LIT11_W], dec.lit11};
            CTL_RET, CTL_RETLW: nxt_pc = stk_mem[SP_W'(sp_ff - 1'b1)];
            default: nxt_pc = skip_take ? PC_W'(pc_ff + 13'h0002) : pc_inc;
        endcase
    end

    // Instruction capture; a forced NOP cycle discards the fetched word
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ir_ff <= NOP_WORD;
        end else if (ph == PH_Q1) begin
            ir_ff <= nop_ff ? NOP_WORD : INSTR_WORD;
        end
    end

    // File read in the second and third phases, even for write-only forms
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rd_ff <= 1'b0;
            faddr_ff <= 7'h00;
            port_rd_ff <= 1'b0;
            opnd_ff <= 8'h00;
        end else if (ph == PH_Q2) begin
            rd_ff <= dec.uses_file;
            faddr_ff <= dec.faddr;
            port_rd_ff <= dec.uses_file && (dec.faddr == FIRST_IO_PORT_ADDR);
        end else if (ph == PH_Q3) begin
            rd_ff <= 1'b0;
            port_rd_ff <= 1'b0;
            // pins rather than the output latch
            opnd_ff <= port_rd_ff ? PORT_PINS : FILE_RDATA;
        end
    end

    // Result write-back, accumulator and flags in the fourth phase
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_ff <= 1'b0;
            wdata_ff <= 8'h00;
            w_ff <= W_RESET;
            flg_ff <= '0;
        end else if (ph == PH_Q4) begin
            wr_ff <= dec.wr_file;
            wdata_ff <= alu_res;
            if (dec.wr_w) begin
                w_ff <= alu_res;
            end else if (dec.ctl == CTL_RETLW) begin
                w_ff <= dec.lit8;
            end
            // Only the flags that the operation names are replaced
            flg_ff <= iwd_flags_t'((alu_flg & alu_upd) | (flg_ff & ~alu_upd));
        end else begin
            wr_ff <= 1'b0;
        end
    end

    // Program counter, NOP cycle marker and stack pointer
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pc_ff <= PC_RESET;
            nop_ff <= 1'b0;
            sp_ff <= '0;
        end else if (ph == PH_Q4) begin
            if (nop_ff) begin
                nop_ff <= 1'b0;
            end else begin
                nop_ff <= two_cycle;
                pc_ff <= nxt_pc;
                if (dec.ctl == CTL_CALL) begin
                    sp_ff <= SP_W'(sp_ff + 1'b1);
                end else if (dec.ctl inside {CTL_RET, CTL_RETLW}) begin
                    sp_ff <= SP_W'(sp_ff - 1'b1);
                end
            end
        end
    end

    // Return stack storage; needs no reset, the pointer guards it
    always_ff @(posedge REF_CLK) begin
        if (ph == PH_Q4 && !nop_ff && dec.ctl == CTL_CALL) begin
            stk_mem[sp_ff] <= pc_inc;
        end
    end

    assign PROG_ADDR = pc_ff;
    assign FILE_ADDR = faddr_ff;
    assign FILE_RD = rd_ff;
    assign FILE_WR = wr_ff;
    assign FILE_WDATA = wdata_ff;
    assign PORT_READ = port_rd_ff;
    assign ACCUM = w_ff;
    assign FLAGS = flg_ff;
    assign NOP_CYCLE = nop_ff;

    chk_word_capture: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ph == PH_Q1 && !nop_ff |=> ir_ff == $past(INSTR_WORD))
        else $error("instruction word not captured");
    chk_class_sort: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (ir_ff[13:12] == 2'b01) == (dec.cls == CLS_BIT))
        else $error("bit class mis-sorted");
    chk_dest_w: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ph == PH_Q4 && dec.cls == CLS_BYTE && dec.uses_file && !ir_ff[7]
        |=> !FILE_WR && ACCUM == $past(alu_res))
        else $error("d=0 result not in accumulator");
    chk_file_addr: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $rose(FILE_RD) |-> FILE_ADDR == ir_ff[6:0] && FILE_ADDR <= FADDR_LAST)
        else $error("file address mismatch");
    chk_bit_only: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        FILE_WR && dec.cls == CLS_BIT |-> (FILE_WDATA ^ opnd_ff) == (8'h01 << dec.bsel) ||
        FILE_WDATA == opnd_ff)
        else $error("bit op changed other bits");
    chk_goto_target: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ph == PH_Q4 && !nop_ff && dec.ctl == CTL_GOTO |=> PROG_ADDR[10:0] == $past(ir_ff[10:0]))
        else $error("jump target wrong");
    chk_cycle_len: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ph == PH_Q1 |=> ph == PH_Q2 ##1 ph == PH_Q3 ##1 ph == PH_Q4 ##1 ph == PH_Q1)
        else $error("cycle is not four periods");
    chk_nop_cycle: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ph == PH_Q4 && !nop_ff && two_cycle |=> NOP_CYCLE ##2 !FILE_RD ##2 !FILE_WR)
        else $error("two-cycle NOP missing");
    chk_read_first: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ph == PH_Q2 && dec.uses_file |=> FILE_RD ##1 ph == PH_Q4 && !FILE_WR)
        else $error("file operand not read");
    chk_port_clear: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ph == PH_Q2 && ir_ff[13:7] == 7'h03 && ir_ff[6:0] == FIRST_IO_PORT_ADDR |=> PORT_READ)
        else $error("port clear did not read port");
    chk_dont_care: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ir_ff[13:7] == 7'h00 && ir_ff[4:0] == 5'h00 |-> dec.ctl == CTL_NONE && !dec.wr_w &&
        !dec.wr_file)
        else $error("don't-care bits changed decode");
    chk_acc_timing: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $changed(ACCUM) |-> $past(ph) == PH_Q4)
        else $error("accumulator changed outside write phase");
    chk_pin_read: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ph == PH_Q3 && port_rd_ff |=> opnd_ff == $past(PORT_PINS))
        else $error("port read not from pins");
    chk_add_lit: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ph == PH_Q4 && dec.cls == CLS_LIT && dec.alu_op == ALU_ADD
        |=> ACCUM == 8'($past(w_ff) + $past(ir_ff[7:0])) && FLAGS.z == (ACCUM == 8'h00))
        else $error("add literal wrong");

endmodule : iwd_core

`default_nettype wire

// ==== test/iwd_prog_mem.sv ====
// Program memory model that supplies instruction words to the core
`default_nettype none

module iwd_prog_mem (
    input wire logic [12:0] addr,
    output logic [13:0] word
);
    timeunit 1ns;
    timeprecision 1ps;
    // Word store, loaded by the bench while reset is held
    logic [13:0] rom [0:15];
    // Out-of-range addresses read as a no-op, so a runaway counter stays harmless
    assign word = (addr < 13'h0010) ? rom[addr[3:0]] : 14'h0000;
endmodule : iwd_prog_mem

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the instruction word decoder
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import iwd_pkg::*;
    logic ref_clk, rstn, file_rd, file_wr, port_read, nop_cycle, rd_seen;
    logic [13:0] instr_word;
    logic [12:0] prog_addr;
    logic [7:0] file_rdata, port_pins, accum, file_wdata, k1, k2, v;
    logic [6:0] file_addr, f;
    logic [2:0] b, fl;
    iwd_flags_t flags;
    logic [7:0] fmem [0:127];
    int bad_count, samples_checked, cycles, port_cnt;

    iwd_core #(.STACK_DEPTH(8)) i_iwd_core (.REF_CLK(ref_clk), .RSTN(rstn),
        .INSTR_WORD(instr_word), .FILE_RDATA(file_rdata), .PORT_PINS(port_pins),
        .PROG_ADDR(prog_addr), .FILE_ADDR(file_addr), .FILE_RD(file_rd),
        .FILE_WR(file_wr), .FILE_WDATA(file_wdata), .PORT_READ(port_read),
        .ACCUM(accum), .FLAGS(flags), .NOP_CYCLE(nop_cycle));
    iwd_prog_mem i_iwd_prog_mem (.addr(prog_addr), .word(instr_word));

    // File space answers only while read; otherwise it shows the inverse to expose late sampling
    assign file_rdata = file_rd ? fmem[file_addr] : ~fmem[file_addr];

    // Report one comparison
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Carry, nibble carry and zero of an 8-bit add
    function automatic logic [2:0] add_flags(input logic [7:0] a, input logic [7:0] c);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, c};
        return {s[8], ({1'b0, a[3:0]} + {1'b0, c[3:0]}) > 5'h0F, s[7:0] == 8'h00};
    endfunction : add_flags

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // Wait whole instruction cycles, then let the edge's updates settle
    task automatic step(input int n);
        repeat (4 * n) @(posedge ref_clk);
        #1;
    endtask : step

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // File store, read-before-write watch, port reads and the hang limit
    always @(posedge ref_clk) begin
        cycles++;
        if (file_wr) begin
            fmem[file_addr] <= file_wdata;
            check(rd_seen, 1'b1);
            rd_seen <= 1'b0;
        end
        if (file_rd) begin
            rd_seen <= 1'b1;
        end
        if (port_read) begin
            port_cnt++;
        end
        if (cycles > 400) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        rstn = 1'b0;
        rd_seen = 1'b0;
        void'($urandom(16));
        k1 = $urandom;
        k2 = $urandom;
        v = $urandom;
        b = $urandom;
        port_pins = $urandom;
        f = 7'h20 + 7'($urandom % 64);
        for (int i = 0; i < 128; i++) begin
            fmem[i] = $urandom;
        end
        // Chosen bit starts clear so the set is visible
        v = v & ~(8'h01 << b);
        fmem[f] = v;
        i_iwd_prog_mem.rom = '{14'h3300 | k1, 14'h3F00 | k2, 14'h00FF, 14'h0185,
            14'h0800 | f, 14'h1400 | {b, f}, 14'h1C00 | {b, f}, 14'h30FF, 14'h280A,
            14'h30EE, 14'h305A, 14'h1400 | {b, 7'h05}, 14'h200E, 14'h0060,
            14'h3700 | k2, 14'h0000};
        repeat (4) @(posedge ref_clk);
        #1 rstn = 1'b1;
        step(1);
        check(accum, k1);
        check(prog_addr, 13'h0001);
        step(1);
        fl = add_flags(k1, k2);
        check(accum, 8'(k1 + k2));
        check(flags, fl);
        step(1);
        check(file_wr, 1'b1);
        check(file_addr, 7'h7F);
        check(file_wdata, 8'(k1 + k2));
        step(1);
        check(file_addr, 7'h05);
        check(file_wdata, 8'h00);
        check(flags, {fl[2:1], 1'b1});
        check(port_cnt, 1);
        step(1);
        check(accum, v);
        check(file_wr, 1'b0);
        step(1);
        check(file_wdata, v | (8'h01 << b));
        step(1);
        check(nop_cycle, 1'b1);
        step(1);
        check(accum, v);
        check(prog_addr, 13'h0008);
        step(1);
        check(prog_addr, 13'h000A);
        check(nop_cycle, 1'b1);
        step(2);
        check(accum, 8'h5A);
        step(1);
        check(file_wdata, port_pins | (8'h01 << b));
        check(port_cnt, 2);
        // Call into a literal return, then a no-op with its free bits set
        step(1);
        check(prog_addr, 13'h000E);
        check(nop_cycle, 1'b1);
        step(2);
        check(accum, k2);
        check(prog_addr, 13'h000D);
        step(2);
        check(accum, k2);
        check(prog_addr, 13'h000E);
        check(nop_cycle, 1'b0);
        give_verdict();
    end
endmodule : tb

`default_nettype wire
